/* File: pss_pkg.sv */
// Constants, types and state layout for the slot scheduler.
// Assumes a 100 MHz system clock and a word-addressed Avalon-MM host.
package pss_pkg;
	// Time base
	localparam int CLK_PERIOD_NS = 10;
	localparam int SLOT_UNIT_NS = 500;
	localparam int SLOT_UNIT_CYC = SLOT_UNIT_NS / CLK_PERIOD_NS;
	localparam int FREE_RUN_PERIOD_US = 228;
	localparam int FREE_RUN_CYC = FREE_RUN_PERIOD_US * 1000 / CLK_PERIOD_NS;
	// Shortest spacing of two slots, in slot units (one frame)
	localparam logic [10:0] SLOT_MIN_GAP = 11'h0D0;
	localparam logic [1:0] END_MSGS = 2'h2;
	// Register word indexes
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_SLOTS = 3'h1;
	localparam logic [2:0] REG_STATUS = 3'h2;
	localparam logic [2:0] REG_IRQ_STAT = 3'h3;
	localparam logic [2:0] REG_IRQ_MASK = 3'h4;
	localparam logic [2:0] REG_SAMPLE = 3'h5;
	// Field positions
	localparam int CTRL_LATENCY = 2;
	localparam int CTRL_FREE_RUN = 3;
	localparam int CTRL_LOCK = 4;
	localparam int CTRL_EXT_INIT = 5;
	localparam int CTRL_RETRY_LSB = 8;
	localparam int SLOTS_B_LSB = 16;
	localparam int IRQ_INIT_DONE = 0;
	localparam int IRQ_ST_FAIL = 1;
	localparam int IRQ_FRAME = 2;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [9:0] SLOT_A_RST = 10'h000;
	localparam logic [9:0] SLOT_B_RST = 10'h000;
	// Transmit mode field encodings
	localparam logic [1:0] TM_NORMAL = 2'h0;
	localparam logic [1:0] TM_DOUBLE = 2'h1;
	// Phase 3 message words
	localparam logic [9:0] MSG_BUSY = 10'h1A0;
	localparam logic [9:0] MSG_READY = 10'h1A1;
	localparam logic [9:0] MSG_DEFECT = 10'h1A2;
	typedef enum logic [1:0] {PH_INIT12, PH_BUSY, PH_END, PH_RUN} pss_phase_t;
	typedef enum logic [1:0] {K_DATA, K_BUSY, K_READY, K_DEFECT} pss_kind_t;
	typedef struct packed {
		logic read;
		logic write;
		logic [2:0] address;
		logic [31:0] writedata;
	} pss_avs_req_t;
	typedef struct packed {
		logic start;
		logic slot_b;
		pss_kind_t kind;
		logic [9:0] word;
	} pss_tx_t;
	typedef struct packed {
		logic [1:0] mode;
		logic latency;
		logic free_run;
		logic user_lock;
		logic ext_init;
		logic [2:0] retry_limit;
		logic [9:0] slot_a;
		logic [9:0] slot_b;
	} pss_cfg_t;
	typedef struct packed {
		logic sync_meta;
		logic sync_sync;
		logic sync_prev;
		pss_cfg_t cfg;
		pss_phase_t phase;
		logic [2:0] retries;
		logic st_passed;
		logic st_start;
		logic prog_mode;
		logic [1:0] end_cnt;
		logic [5:0] pre;
		logic [10:0] tick;
		logic armed_a;
		logic armed_b;
		logic [9:0] held;
		logic [15:0] free_cnt;
		pss_tx_t tx;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic irq;
		logic waitreq;
		logic [31:0] rdata;
	} pss_state_t;
endpackage : pss_pkg

/* File: pss_rx_model.sv */
// Control-unit receiver model: makes sync pulses and counts frames.
// Assumes the bench asks for a pulse with a one-cycle fire strobe.
`timescale 1ns/1ns
module pss_rx_model
	import pss_pkg::*;
(
	input wire logic clk,
	input wire logic fire,
	input wire pss_tx_t tx,
	output logic sync_pin,
	output int n_frames
);
	logic [3:0] hold = 4'h0;
	int cnt = 0;
	assign n_frames = cnt;
	// Pulse held ten cycles so the two-flop synchroniser sees it
	always @(posedge clk) begin
		if (fire)
			hold <= 4'hA;
		else if (hold != 4'h0)
			hold <= hold - 4'h1;
		if (tx.start === 1'h1)
			cnt <= cnt + 1;
	end
	// Line idles low between pulses
	assign sync_pin = (hold != 4'h0);
endmodule : pss_rx_model

/* File: pss_slot_scheduler.sv */
// Response scheduler for a satellite sensor on a current-loop sensor bus:
// phase 3 messaging, free-running transmission and sync-driven slots.
// Assumes sample, self-test and command-decoder inputs on clk; the sync
// pulse comes straight from the pin.
`timescale 1ns/1ns
module pss_slot_scheduler
	import pss_pkg::*;
#(
	parameter int FREE_RUN_CYCLES = FREE_RUN_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire pss_avs_req_t avs_req,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic sync_pin,
	input wire logic [9:0] sample_in,
	input wire logic init12_done,
	input wire logic prog_cmd_seen,
	input wire logic st_done,
	input wire logic st_pass,
	output logic st_start,
	output logic prog_mode,
	output pss_tx_t tx,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Second slot must start at least one frame after the first
	function automatic logic slot_conflict(input logic [9:0] a,
		input logic [9:0] b);
		logic [10:0] a_end;
		a_end = {1'b0, a} + SLOT_MIN_GAP;
		slot_conflict = ({1'b0, b} < a_end);
	endfunction : slot_conflict

	// Slot reached: armed, first cycle of a tick, tick equals the offset
	function automatic logic slot_hit(input logic armed,
		input logic [5:0] pre, input logic [10:0] tick,
		input logic [9:0] slot);
		slot_hit = armed && (pre == 6'h00) && (tick == {1'b0, slot});
	endfunction : slot_hit

	// Message word for the current init phase
	function automatic logic [9:0] msg_word(input pss_phase_t ph,
		input logic passed);
		if (ph == PH_BUSY) begin
			msg_word = MSG_BUSY;
		end else if (passed) begin
			msg_word = MSG_READY;
		end else begin
			msg_word = MSG_DEFECT;
		end
	endfunction : msg_word

	// Frame kind that goes with the message word
	function automatic pss_kind_t msg_kind(input pss_phase_t ph,
		input logic passed);
		if (ph == PH_BUSY) begin
			msg_kind = K_BUSY;
		end else if (ph == PH_RUN) begin
			msg_kind = K_DATA;
		end else if (passed) begin
			msg_kind = K_READY;
		end else begin
			msg_kind = K_DEFECT;
		end
	endfunction : msg_kind

	////////////////////////////////////////////////////////////////////////
	// State

	pss_state_t s;
	pss_state_t next_s;
	pss_state_t rst_s;

	logic sync_edge;
	logic free_run_select_on;
	logic dsr_on;
	logic conflict;
	logic hit_a;
	logic hit_b;
	logic fire_a;
	logic fire_b;
	logic fire_free;
	logic req;
	logic take;
	logic [2:0] ev;
	logic [31:0] rd_mux;
	logic [31:0] ctrl_word;
	logic [31:0] status_word;

	////////////////////////////////////////////////////////////////////////
	// Decodes of configuration and pending events

	// Mode selection from the control word and the slot A offset
	assign free_run_select_on = (s.cfg.mode == TM_NORMAL) && s.cfg.free_run
		&& (s.cfg.slot_a == 10'h000);
	// Other transmit codes act as synchronous modes with no second slot and
	// no sync-edge sampling, so an unexpected code never doubles the traffic
	assign dsr_on = (s.cfg.mode == TM_DOUBLE);
	assign conflict = slot_conflict(s.cfg.slot_a, s.cfg.slot_b);
	// Only the second synchroniser stage feeds the edge detector
	assign sync_edge = s.sync_sync & ~s.sync_prev;
	// Slot hits on the first cycle of the matching half-microsecond tick
	assign hit_a = slot_hit(s.armed_a, s.pre, s.tick,
		s.cfg.slot_a);
	assign hit_b = slot_hit(s.armed_b, s.pre, s.tick,
		s.cfg.slot_b);
	assign fire_free = free_run_select_on
		&& (s.free_cnt == 16'(FREE_RUN_CYCLES - 1));
	assign fire_a = free_run_select_on ? fire_free : hit_a;
	assign fire_b = !free_run_select_on && hit_b;
	assign req = avs_req.read | avs_req.write;
	assign take = req && !s.waitreq;

	// Register views
	assign ctrl_word = {21'h000000, s.cfg.retry_limit, 2'h0,
		s.cfg.ext_init, s.cfg.user_lock, s.cfg.free_run,
		s.cfg.latency, s.cfg.mode};
	assign status_word = {21'h000000, conflict, free_run_select_on, s.prog_mode,
		s.st_passed, s.retries, 2'h0, s.phase};

	// Read multiplexer; unmapped words read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (avs_req.address)
			REG_CTRL: rd_mux = ctrl_word;
			REG_SLOTS: rd_mux = {6'h00, s.cfg.slot_b, 6'h00, s.cfg.slot_a};
			REG_STATUS: rd_mux = status_word;
			REG_IRQ_STAT: rd_mux = {29'h0, s.irq_stat};
			REG_IRQ_MASK: rd_mux = {29'h0, s.irq_mask};
			REG_SAMPLE: rd_mux = {22'h0, s.held};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Reset image

	// Built from the package constants so the control word reads back
	// its reset value without a second table to keep in step
	always_comb begin
		rst_s = '0;
		rst_s.cfg.mode = CTRL_RST[1:0];
		rst_s.cfg.latency = CTRL_RST[CTRL_LATENCY];
		rst_s.cfg.free_run = CTRL_RST[CTRL_FREE_RUN];
		rst_s.cfg.user_lock = CTRL_RST[CTRL_LOCK];
		rst_s.cfg.ext_init = CTRL_RST[CTRL_EXT_INIT];
		rst_s.cfg.retry_limit = CTRL_RST[CTRL_RETRY_LSB +: 3];
		rst_s.cfg.slot_a = SLOT_A_RST;
		rst_s.cfg.slot_b = SLOT_B_RST;
		rst_s.phase = PH_INIT12;
		rst_s.tx.kind = K_DATA;
		rst_s.waitreq = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		next_s = s;
		ev = 3'h0;
		// Strobes default low so each lasts a single cycle
		next_s.tx.start = 1'b0;
		next_s.st_start = 1'b0;

		// Pin synchroniser
		// Two stages before any logic looks at the pin; the third flop
		// only remembers the last level for the rising-edge detect
		next_s.sync_meta = sync_pin;
		next_s.sync_sync = s.sync_meta;
		next_s.sync_prev = s.sync_sync;

		// Half-microsecond slot timer, saturating past the last slot
		if (s.pre == 6'(SLOT_UNIT_CYC - 1)) begin
			next_s.pre = 6'h00;
			if (s.tick != 11'h7FF) begin
				next_s.tick = s.tick + 11'h001;
			end
		end else begin
			next_s.pre = s.pre + 6'h01;
		end
		if (hit_a) begin
			next_s.armed_a = 1'b0;
		end
		if (hit_b) begin
			next_s.armed_b = 1'b0;
		end

		// Sync edge restarts slot timing; free-run mode ignores it
		// A sync edge before slot B has fired re-arms both slots, so
		// the late slot of the earlier period is dropped, not sent
		if (sync_edge && !free_run_select_on) begin
			next_s.pre = 6'h00;
			next_s.tick = 11'h000;
			next_s.armed_a = 1'b1;
			next_s.armed_b = dsr_on && !conflict;
			// Simultaneous sampling takes the sample at the edge
			if (s.cfg.mode == TM_NORMAL && !s.cfg.latency) begin
				next_s.held = sample_in;
			end
		end

		// Free-running period counter
		// Counter is 16 bits wide: FREE_RUN_CYCLES must not exceed
		// 65536, which the default period meets with room to spare
		if (!free_run_select_on || fire_free) begin
			next_s.free_cnt = 16'h0000;
		end else begin
			next_s.free_cnt = s.free_cnt + 16'h0001;
		end

		// Programming entry is watched only before phase 3
		if (s.phase == PH_INIT12 && prog_cmd_seen
			&& !s.cfg.user_lock) begin
			next_s.prog_mode = 1'b1;
		end

		// Initialization phase sequencing
		// Phase 3 has no fixed length here: it lasts as long as the
		// self-test and its retries, then two closing slot-A frames, so a
		// slow sync period simply stretches it
		unique case (s.phase)
			PH_INIT12: begin
				if (init12_done && !s.prog_mode) begin
					next_s.phase = PH_BUSY;
					next_s.retries = 3'h0;
					next_s.st_passed = 1'b0;
					next_s.st_start = 1'b1;
				end
			end
			PH_BUSY: begin
				if (st_done && st_pass) begin
					next_s.st_passed = 1'b1;
					next_s.end_cnt = 2'h0;
					next_s.phase = PH_END;
				end else if (st_done) begin
					ev[IRQ_ST_FAIL] = 1'b1;
					if (s.retries < s.cfg.retry_limit) begin
						// Restart the self-test; the phase stays at busy
						next_s.retries = s.retries + 3'h1;
						next_s.st_start = 1'b1;
					end else begin
						next_s.end_cnt = 2'h0;
						next_s.phase = PH_END;
					end
				end
			end
			PH_END: begin
				// Closing messages pace the end of phase 3
				if (fire_a && s.end_cnt == END_MSGS - 2'h1) begin
					next_s.phase = PH_RUN;
					ev[IRQ_INIT_DONE] = 1'b1;
				end else if (fire_a) begin
					next_s.end_cnt = s.end_cnt + 2'h1;
				end
			end
			PH_RUN: begin
				next_s.phase = PH_RUN;
			end
		endcase

		// First slot or free-run frame
		if (fire_a && s.phase != PH_INIT12) begin
			next_s.tx.start = 1'b1;
			next_s.tx.slot_b = 1'b0;
			next_s.tx.kind = msg_kind(s.phase, s.st_passed);
			ev[IRQ_FRAME] = 1'b1;
			if (s.phase != PH_RUN) begin
				next_s.tx.word = msg_word(s.phase, s.st_passed);
			end else if (free_run_select_on) begin
				next_s.held = sample_in;
				next_s.tx.word = sample_in;
			end else if (dsr_on || s.cfg.latency) begin
				// Latch at the slot itself for least latency
				next_s.held = sample_in;
				next_s.tx.word = sample_in;
			end else begin
				next_s.tx.word = s.held;
			end
		end else if (fire_b && s.phase != PH_INIT12) begin
			// Second slot of double rate; armed only without conflict
			next_s.tx.start = 1'b1;
			next_s.tx.slot_b = 1'b1;
			next_s.tx.kind = msg_kind(s.phase, s.st_passed);
			ev[IRQ_FRAME] = 1'b1;
			if (s.phase != PH_RUN) begin
				next_s.tx.word = msg_word(s.phase, s.st_passed);
			end else begin
				next_s.held = sample_in;
				next_s.tx.word = sample_in;
			end
		end

		// Bus slave: one wait cycle, then the answer for one cycle
		// The wait state keeps the read path registered; the host may
		// present its next request on the edge after the answer
		if (req && s.waitreq) begin
			next_s.waitreq = 1'b0;
			next_s.rdata = rd_mux;
		end else begin
			next_s.waitreq = 1'b1;
		end
		if (take && avs_req.write) begin
			unique case (avs_req.address)
				REG_CTRL: begin
					next_s.cfg.mode = avs_req.writedata[1:0];
					next_s.cfg.latency = avs_req.writedata[CTRL_LATENCY];
					next_s.cfg.free_run = avs_req.writedata[CTRL_FREE_RUN];
					next_s.cfg.user_lock = avs_req.writedata[CTRL_LOCK];
					next_s.cfg.ext_init = avs_req.writedata[CTRL_EXT_INIT];
					next_s.cfg.retry_limit =
						avs_req.writedata[CTRL_RETRY_LSB +: 3];
				end
				REG_SLOTS: begin
					next_s.cfg.slot_a = avs_req.writedata[9:0];
					next_s.cfg.slot_b = avs_req.writedata[SLOTS_B_LSB +: 10];
				end
				REG_IRQ_MASK: next_s.irq_mask = avs_req.writedata[2:0];
				default: next_s.cfg = s.cfg;
			endcase
		end

		// Read clears only the bits shown; a new event still wins
		if (take && avs_req.read && avs_req.address == REG_IRQ_STAT) begin
			next_s.irq_stat = s.irq_stat & ~s.rdata[2:0];
		end
		next_s.irq_stat = next_s.irq_stat | ev;
		next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	// Synchronous reset loads the constant reset image
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s <= rst_s;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from the state register

	assign avs_readdata = s.rdata;
	assign avs_waitrequest = s.waitreq;
	assign st_start = s.st_start;
	assign prog_mode = s.prog_mode;
	assign tx = s.tx;
	assign irq = s.irq;

endmodule : pss_slot_scheduler

/* File: pss_slot_scheduler_assertions.sv */
// Checker for the slot scheduler, bound to its top module.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ns
module pss_slot_scheduler_chk
	import pss_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire pss_avs_req_t avs_req,
	input wire logic avs_waitrequest,
	input wire logic prog_cmd_seen,
	input wire logic st_done,
	input wire logic st_pass,
	input wire logic st_start,
	input wire logic prog_mode,
	input wire pss_tx_t tx
);
	logic [9:0] last_a;
	logic [1:0] end_cnt;
	logic st_ok;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////
	// Shadow of last slot-A word, closing count and last self-test verdict
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			last_a <= 10'h000;
			end_cnt <= 2'h0;
			st_ok <= 1'h0;
		end else begin
			if (st_done)
				st_ok <= st_pass;
			if (tx.start && !tx.slot_b) begin
				last_a <= tx.word;
				// Saturates so a long run cannot wrap back to zero
				if (tx.kind inside {K_READY, K_DEFECT} && end_cnt != 2'h3)
					end_cnt <= end_cnt + 2'h1;
			end
		end
	end
	property p_bus_wait;
		(avs_req.read || avs_req.write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_bus_wait: assert property (p_bus_wait) else $error("no bus answer");
	property p_st_stop;
		st_done && st_pass |=> !st_start [*8];
	endproperty
	a_st_stop: assert property (p_st_stop) else $error("retest after pass");
	property p_prog_cause;
		$rose(prog_mode) |-> $past(prog_cmd_seen) || $past(prog_cmd_seen, 2);
	endproperty
	a_prog_cause: assert property (p_prog_cause) else $error("prog no cmd");
	property p_prog_sticky;
		prog_mode |=> prog_mode;
	endproperty
	a_prog_sticky: assert property (p_prog_sticky) else $error("prog lost");
	property p_init_copy;
		tx.start && tx.slot_b && tx.kind != K_DATA |-> tx.word == last_a;
	endproperty
	a_init_copy: assert property (p_init_copy) else $error("slot copy");
	property p_data_after_two;
		tx.start && tx.kind == K_DATA |-> end_cnt == 2'h2;
	endproperty
	a_data_after_two: assert property (p_data_after_two) else $error("early");
	property p_no_busy_late;
		tx.start && end_cnt != 2'h0 |-> tx.kind != K_BUSY;
	endproperty
	a_no_busy_late: assert property (p_no_busy_late) else $error("late busy");
	property p_ready_pass;
		tx.start && tx.kind == K_READY |-> st_ok;
	endproperty
	a_ready_pass: assert property (p_ready_pass) else $error("ready no pass");
	property p_defect_fail;
		tx.start && tx.kind == K_DEFECT |-> !st_ok;
	endproperty
	a_defect_fail: assert property (p_defect_fail) else $error("bad defect");
endmodule : pss_slot_scheduler_chk
bind pss_slot_scheduler pss_slot_scheduler_chk u_chk (.clk(clk), .rst_b(rst_b),
	.avs_req(avs_req), .avs_waitrequest(avs_waitrequest), .tx(tx),
	.prog_cmd_seen(prog_cmd_seen), .st_done(st_done), .st_pass(st_pass),
	.st_start(st_start), .prog_mode(prog_mode));

/* File: pss_slot_scheduler_tb_top.sv */
// Self-checking bench for the slot scheduler.
// Assumes the receiver model and the bound checker are compiled with it.
`timescale 1ns/1ns
module pss_slot_scheduler_tb_top
	import pss_pkg::*;
;
	localparam int FR = 50;
	logic clk = 1'h0, rst_b = 1'h0, fire = 1'h0, init12_done = 1'h0;
	logic prog_cmd_seen = 1'h0, st_done = 1'h0, st_pass = 1'h0;
	logic [9:0] sample_in = 10'h000;
	pss_avs_req_t avs_req = '0;
	logic [31:0] avs_readdata, q;
	logic avs_waitrequest, st_start, prog_mode, irq, sync_pin;
	pss_tx_t tx;
	int err_count = 0, n_checks = 0, cyc = 0, n_frames, t0, nf;
	pss_slot_scheduler #(.FREE_RUN_CYCLES(FR)) DUT (.clk, .rst_b, .avs_req,
		.avs_readdata, .avs_waitrequest, .sync_pin, .sample_in, .init12_done,
		.prog_cmd_seen, .st_done, .st_pass, .st_start, .prog_mode, .tx, .irq);
	pss_rx_model u_rx (.clk, .fire, .tx, .sync_pin, .n_frames);
	initial begin
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task print_verdict;
		if (err_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	// Request held until waitrequest is seen low; one idle edge after
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		avs_req <= '{read: !w, write: w, address: a, writedata: d};
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'h0);
		q = avs_readdata;
		avs_req <= '0;
		@(posedge clk);
	endtask : bus
	// One-cycle strobe: 1 for the programming command, 0 for a sync
	task automatic pulse(input logic cmd);
		if (cmd)
			prog_cmd_seen <= 1'h1;
		else
			fire <= 1'h1;
		@(posedge clk);
		prog_cmd_seen <= 1'h0;
		fire <= 1'h0;
		repeat (3) @(posedge clk);
	endtask : pulse
	task automatic do_reset;
		init12_done <= 1'h0;
		rst_b <= 1'h0;
		repeat (6) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
	endtask : do_reset
	task automatic st_res(input logic p);
		st_done <= 1'h1;
		st_pass <= p;
		@(posedge clk);
		st_done <= 1'h0;
	endtask : st_res
	task automatic wait_st;
		int n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (st_start !== 1'h1 && n < 200);
		check("st_start", st_start, 1'h1);
	endtask : wait_st
	// Sync pulse; sample changes after the edge but before the slot
	task automatic shot(input logic [9:0] a, input logic [9:0] b);
		sample_in <= a;
		pulse(1'h0);
		repeat (30) @(posedge clk);
		sample_in <= b;
	endtask : shot
	task automatic frame(input logic b, input pss_kind_t k, input logic [9:0] w);
		int n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (tx.start !== 1'h1 && n < 12000);
		check("frame", {tx.start, tx.slot_b, tx.kind, tx.word}, {1'h1, b, k, w});
	endtask : frame
	////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset();
		bus(0, REG_CTRL, 0);
		check("ctrl", q, CTRL_RST);
		bus(0, 3'h7, 0);
		check("unmapped", q, 32'h0);
		bus(1, REG_IRQ_MASK, 32'h7);
		bus(1, REG_CTRL, 32'h0000_0110);
		bus(1, REG_SLOTS, 32'h0000_0002);
		pulse(1'h1);
		check("locked", prog_mode, 1'h0);
		init12_done <= 1'h1;
		wait_st();
		shot(10'h000, 10'h000);
		frame(1'h0, K_BUSY, MSG_BUSY);
		st_res(1'h0);
		wait_st();
		st_res(1'h1);
		for (int i = 0; i < 2; i++) begin
			shot(10'h000, 10'h000);
			frame(1'h0, K_READY, MSG_READY);
		end
		repeat (4) @(posedge clk);
		check("irq", irq, 1'h1);
		bus(0, REG_IRQ_STAT, 0);
		check("irq_stat", q, 32'h7);
		bus(0, REG_IRQ_STAT, 0);
		check("cleared", q, 32'h0);
		bus(1, REG_IRQ_MASK, 32'h0);
		shot(10'h155, 10'h2AA);
		frame(1'h0, K_DATA, 10'h155);
		repeat (4) @(posedge clk);
		check("masked", irq, 1'h0);
		bus(0, REG_SAMPLE, 0);
		check("sample", q, 32'h0000_0155);
		bus(1, REG_CTRL, 32'h0000_0114);
		shot(10'h0F0, 10'h30F);
		frame(1'h0, K_DATA, 10'h30F);
		// Latency clear here: double rate must still latch at the slot
		bus(1, REG_CTRL, 32'h0000_0111);
		bus(1, REG_SLOTS, 32'h00D2_0002);
		shot(10'h111, 10'h222);
		frame(1'h0, K_DATA, 10'h222);
		sample_in <= 10'h333;
		frame(1'h1, K_DATA, 10'h333);
		bus(1, REG_SLOTS, 32'h00D1_0002);
		shot(10'h0AA, 10'h0AB);
		frame(1'h0, K_DATA, 10'h0AB);
		@(posedge clk);
		nf = n_frames;
		repeat (11000) @(posedge clk);
		check("slot_b", n_frames, nf);
		bus(1, REG_SLOTS, 32'h0);
		bus(1, REG_CTRL, 32'h0000_0118);
		frame(1'h0, K_DATA, 10'h0AB);
		t0 = cyc;
		pulse(1'h0);
		frame(1'h0, K_DATA, 10'h0AB);
		check("period", cyc - t0, FR);
		do_reset();
		bus(1, REG_CTRL, 32'h0000_0001);
		bus(1, REG_SLOTS, 32'h00D2_0002);
		init12_done <= 1'h1;
		wait_st();
		st_res(1'h0);
		shot(10'h000, 10'h000);
		frame(1'h0, K_DEFECT, MSG_DEFECT);
		frame(1'h1, K_DEFECT, MSG_DEFECT);
		bus(0, REG_STATUS, 0);
		check("status", q, 32'h0000_0002);
		do_reset();
		pulse(1'h1);
		check("prog", prog_mode, 1'h1);
		print_verdict();
	end
	// Hang guard well above the expected run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count++;
			print_verdict();
		end
	end
endmodule : pss_slot_scheduler_tb_top
